// ===== pkg/pdmc_map.vh
// register offsets, field positions, reset values and counts of the microphone capture block
`ifndef PDMC_MAP_VH
`define PDMC_MAP_VH

`define PDMC_OFF_START      12'h000
`define PDMC_OFF_STOP       12'h004
`define PDMC_OFF_EV_STARTED 12'h100
`define PDMC_OFF_EV_STOPPED 12'h104
`define PDMC_OFF_EV_END     12'h108
`define PDMC_OFF_IRQ_ENABLE_MASK      12'h300
`define PDMC_OFF_IRQ_ENABLE_SET   12'h304
`define PDMC_OFF_IRQ_ENABLE_CLEAR   12'h308
`define PDMC_OFF_ENABLE     12'h500
`define PDMC_OFF_CLKFREQ    12'h504
`define PDMC_OFF_MODE       12'h508
`define PDMC_OFF_LEFT_GAIN      12'h518
`define PDMC_OFF_RIGHT_GAIN      12'h51c
`define PDMC_OFF_RATIO      12'h520
`define PDMC_OFF_PSEL_CLK   12'h540
`define PDMC_OFF_PSEL_DIN   12'h544
`define PDMC_OFF_PTR        12'h560
`define PDMC_OFF_MAXCNT     12'h564

`define PDMC_BIT_STARTED    0
`define PDMC_BIT_STOPPED    1
`define PDMC_BIT_END        2
`define PDMC_BIT_ENABLE     0
`define PDMC_BIT_OPERATION  0
`define PDMC_BIT_EDGE       1
`define PDMC_BIT_RATIO      0
`define PDMC_BIT_CONNECT    31

`define PDMC_RST_ZERO       32'h00000000
`define PDMC_RST_CLKFREQ    32'h08400000
`define PDMC_RST_GAIN       7'h28
`define PDMC_RST_PSEL       32'hffffffff

`define PDMC_RATIO64        7'h40
`define PDMC_RATIO80        7'h50

`define PDMC_RESP_OKAY      2'h0
`define PDMC_RESP_SLVERR    2'h2

`endif

// ===== design/pdmc_capture.v
// microphone capture block: register slave, clock generator, bit sampler, packing and dma writer
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "pdmc_map.vh"

module pdmc_capture (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address, data and response
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // dma write port toward ram
  output reg         dma_valid,
  output reg  [31:0] dma_addr,
  output reg  [31:0] dma_wdata,
  input  wire        dma_ready,
  // microphone clock pin and gpio fallback
  input  wire        gpio_clk_out,
  input  wire        gpio_clk_oe,
  output reg         mic_bit_clock_out,
  output reg         mic_bit_clock_oe,
  output reg  [5:0]  clk_pin_number,
  // microphone data pin
  input  wire        mic_data_in,
  output reg  [5:0]  din_pin_number,
  // interrupt
  output reg         irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_STOP = 2'h2;

  // register file
  reg  [2:0]  ev;
  reg  [2:0]  irq_enable_mask;
  reg         enable;
  reg  [31:0] clk_freq;
  reg  [1:0]  mode;
  reg  [6:0]  gain_l;
  reg  [6:0]  gain_r;
  reg         ratio;
  reg  [31:0] psel_clk;
  reg  [31:0] psel_din;
  reg  [31:0] ptr_shadow;
  reg  [31:0] maxcnt_shadow;
  reg         start_pulse;
  reg         stop_pulse;

  // axi write holding
  reg         aw_have;
  reg         w_have;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // core state
  reg  [1:0]  state;
  reg  [2:0]  ev_set;
  reg  [31:0] work_ptr;
  reg  [31:0] work_cnt;
  reg  [31:0] done_cnt;
  reg  [31:0] word_addr;
  reg  [15:0] pack_low;
  reg         pack_half;

  // clock generation and sampling
  reg  [31:0] nco;
  reg         mic_clk;
  reg         din_meta;
  reg         din_sync;
  reg  [6:0]  ones_l;
  reg  [6:0]  ones_r;
  reg  [6:0]  bit_cnt;
  reg  [15:0] smp_l;
  reg  [15:0] smp_r;
  reg         smp_valid;

  wire        wr_go   = aw_have && w_have && !s_axi_bvalid;
  wire [31:0] wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire        route_clk = enable && !psel_clk[`PDMC_BIT_CONNECT];
  wire        route_din = enable && !psel_din[`PDMC_BIT_CONNECT];
  wire [32:0] nco_sum = {1'b0, nco} + {1'b0, clk_freq};
  wire        run_clk = enable && (state != ST_IDLE);
  wire        rise    = run_clk && !mic_clk && nco_sum[31];
  wire        fall    = run_clk && mic_clk && !nco_sum[31];
  wire [6:0]  ratio_n = ratio ? `PDMC_RATIO80 : `PDMC_RATIO64;
  wire        din_bit = route_din & din_sync;

  function [15:0] to_pcm;
    input [6:0] ones;
    input [6:0] n;
    reg   [7:0] diff;
    begin
      diff   = {ones, 1'b0} - {1'b0, n};
      to_pcm = {diff, 8'h00};
    end
  endfunction

  // register read mux
  reg  [31:0] rd_val;
  reg         rd_ok;
  always @* begin
    rd_val = `PDMC_RST_ZERO;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `PDMC_OFF_START:      rd_val = `PDMC_RST_ZERO;
      `PDMC_OFF_STOP:       rd_val = `PDMC_RST_ZERO;
      `PDMC_OFF_EV_STARTED: rd_val = {31'h0, ev[`PDMC_BIT_STARTED]};
      `PDMC_OFF_EV_STOPPED: rd_val = {31'h0, ev[`PDMC_BIT_STOPPED]};
      `PDMC_OFF_EV_END:     rd_val = {31'h0, ev[`PDMC_BIT_END]};
      `PDMC_OFF_IRQ_ENABLE_MASK:      rd_val = {29'h0, irq_enable_mask};
      `PDMC_OFF_IRQ_ENABLE_SET:   rd_val = {29'h0, irq_enable_mask};
      `PDMC_OFF_IRQ_ENABLE_CLEAR:   rd_val = {29'h0, irq_enable_mask};
      `PDMC_OFF_ENABLE:     rd_val = {31'h0, enable};
      `PDMC_OFF_CLKFREQ:    rd_val = clk_freq;
      `PDMC_OFF_MODE:       rd_val = {30'h0, mode};
      `PDMC_OFF_LEFT_GAIN:      rd_val = {25'h0, gain_l};
      `PDMC_OFF_RIGHT_GAIN:      rd_val = {25'h0, gain_r};
      `PDMC_OFF_RATIO:      rd_val = {31'h0, ratio};
      `PDMC_OFF_PSEL_CLK:   rd_val = psel_clk;
      `PDMC_OFF_PSEL_DIN:   rd_val = psel_din;
      `PDMC_OFF_PTR:        rd_val = ptr_shadow;
      `PDMC_OFF_MAXCNT:     rd_val = maxcnt_shadow;
      default:              rd_ok  = 1'b0;
    endcase
  end

  // axi handshakes and register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PDMC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `PDMC_RESP_OKAY;
      s_axi_rdata   <= `PDMC_RST_ZERO;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= `PDMC_RST_ZERO;
      w_strb        <= 4'h0;
      ev            <= 3'h0;
      irq_enable_mask         <= 3'h0;
      enable        <= 1'b0;
      clk_freq      <= `PDMC_RST_CLKFREQ;
      mode          <= 2'h0;
      gain_l        <= `PDMC_RST_GAIN;
      gain_r        <= `PDMC_RST_GAIN;
      ratio         <= 1'b0;
      psel_clk      <= `PDMC_RST_PSEL;
      psel_din      <= `PDMC_RST_PSEL;
      ptr_shadow    <= `PDMC_RST_ZERO;
      maxcnt_shadow <= `PDMC_RST_ZERO;
      start_pulse   <= 1'b0;
      stop_pulse    <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      stop_pulse  <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (wr_go) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PDMC_RESP_OKAY;
        case (aw_addr)
          `PDMC_OFF_START: start_pulse <= w_strb[0] & w_data[0];
          `PDMC_OFF_STOP:  stop_pulse  <= w_strb[0] & w_data[0];
          `PDMC_OFF_EV_STARTED: if (w_strb[0]) ev[`PDMC_BIT_STARTED] <= w_data[0];
          `PDMC_OFF_EV_STOPPED: if (w_strb[0]) ev[`PDMC_BIT_STOPPED] <= w_data[0];
          `PDMC_OFF_EV_END:     if (w_strb[0]) ev[`PDMC_BIT_END] <= w_data[0];
          `PDMC_OFF_IRQ_ENABLE_MASK:    if (w_strb[0]) irq_enable_mask <= w_data[2:0];
          `PDMC_OFF_IRQ_ENABLE_SET: if (w_strb[0]) irq_enable_mask <= irq_enable_mask | w_data[2:0];
          `PDMC_OFF_IRQ_ENABLE_CLEAR: if (w_strb[0]) irq_enable_mask <= irq_enable_mask & ~w_data[2:0];
          `PDMC_OFF_ENABLE:   if (w_strb[0]) enable <= w_data[`PDMC_BIT_ENABLE];
          `PDMC_OFF_CLKFREQ:  clk_freq <= (clk_freq & ~wmask) | (w_data & wmask);
          `PDMC_OFF_MODE:     if (w_strb[0]) mode <= w_data[1:0];
          `PDMC_OFF_LEFT_GAIN:    if (w_strb[0]) gain_l <= w_data[6:0];
          `PDMC_OFF_RIGHT_GAIN:    if (w_strb[0]) gain_r <= w_data[6:0];
          `PDMC_OFF_RATIO:    if (w_strb[0]) ratio <= w_data[`PDMC_BIT_RATIO];
          `PDMC_OFF_PSEL_CLK: psel_clk <= (psel_clk & ~wmask) | (w_data & wmask);
          `PDMC_OFF_PSEL_DIN: psel_din <= (psel_din & ~wmask) | (w_data & wmask);
          `PDMC_OFF_PTR:      ptr_shadow <= (ptr_shadow & ~wmask) | (w_data & wmask);
          `PDMC_OFF_MAXCNT:   maxcnt_shadow <= (maxcnt_shadow & ~wmask) | (w_data & wmask);
          default:            s_axi_bresp <= `PDMC_RESP_SLVERR;
        endcase
      end
      ev <= ev_set | (wr_go && aw_addr == `PDMC_OFF_EV_STARTED && w_strb[0] ?
                      {ev[2:1], w_data[0]} :
                      wr_go && aw_addr == `PDMC_OFF_EV_STOPPED && w_strb[0] ?
                      {ev[2], w_data[0], ev[0]} :
                      wr_go && aw_addr == `PDMC_OFF_EV_END && w_strb[0] ?
                      {w_data[0], ev[1:0]} : ev);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? `PDMC_RESP_OKAY : `PDMC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // clock generator, data synchroniser and bit accumulation
  always @(posedge aclk) begin
    if (!aresetn) begin
      nco       <= `PDMC_RST_ZERO;
      mic_clk   <= 1'b0;
      din_meta  <= 1'b0;
      din_sync  <= 1'b0;
      ones_l    <= 7'h00;
      ones_r    <= 7'h00;
      bit_cnt   <= 7'h00;
      smp_l     <= 16'h0000;
      smp_r     <= 16'h0000;
      smp_valid <= 1'b0;
    end else begin
      din_meta  <= mic_data_in;
      din_sync  <= din_meta;
      smp_valid <= 1'b0;
      if (run_clk) begin
        nco     <= nco_sum[31:0];
        mic_clk <= nco_sum[31];
      end else begin
        nco     <= `PDMC_RST_ZERO;
        mic_clk <= 1'b0;
        ones_l  <= 7'h00;
        ones_r  <= 7'h00;
        bit_cnt <= 7'h00;
      end
      if (fall) begin
        if (mode[`PDMC_BIT_EDGE])
          ones_r <= ones_r + {6'h00, din_bit};
        else
          ones_l <= ones_l + {6'h00, din_bit};
      end
      if (rise) begin
        if (bit_cnt == ratio_n - 7'h01) begin
          bit_cnt   <= 7'h00;
          smp_valid <= 1'b1;
          if (mode[`PDMC_BIT_EDGE]) begin
            smp_l  <= to_pcm(ones_l + {6'h00, din_bit}, ratio_n);
            smp_r  <= to_pcm(ones_r, ratio_n);
          end else begin
            smp_l  <= to_pcm(ones_l, ratio_n);
            smp_r  <= to_pcm(ones_r + {6'h00, din_bit}, ratio_n);
          end
          ones_l <= 7'h00;
          ones_r <= 7'h00;
        end else begin
          bit_cnt <= bit_cnt + 7'h01;
          if (mode[`PDMC_BIT_EDGE])
            ones_l <= ones_l + {6'h00, din_bit};
          else
            ones_r <= ones_r + {6'h00, din_bit};
        end
      end
    end
  end

  // capture control, packing and dma
  always @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_IDLE;
      ev_set    <= 3'h0;
      work_ptr  <= `PDMC_RST_ZERO;
      work_cnt  <= `PDMC_RST_ZERO;
      done_cnt  <= `PDMC_RST_ZERO;
      word_addr <= `PDMC_RST_ZERO;
      pack_low  <= 16'h0000;
      pack_half <= 1'b0;
      dma_valid <= 1'b0;
      dma_addr  <= `PDMC_RST_ZERO;
      dma_wdata <= `PDMC_RST_ZERO;
    end else begin
      ev_set <= 3'h0;
      if (dma_valid && dma_ready)
        dma_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          pack_half <= 1'b0;
          if (start_pulse && enable) begin
            work_ptr  <= ptr_shadow;
            work_cnt  <= maxcnt_shadow;
            word_addr <= ptr_shadow;
            done_cnt  <= `PDMC_RST_ZERO;
            ev_set[`PDMC_BIT_STARTED] <= 1'b1;
            state     <= ST_RUN;
          end
        end
        ST_RUN, ST_STOP: begin
          if (stop_pulse)
            state <= ST_STOP;
          if (!enable) begin
            state <= ST_IDLE;
          end else if (smp_valid && !dma_valid) begin
            if (mode[`PDMC_BIT_OPERATION] && !pack_half) begin
              // earlier mono sample waits in low half
              pack_low  <= smp_l;
              pack_half <= 1'b1;
            end else begin
              dma_valid <= 1'b1;
              dma_addr  <= word_addr;
              // later mono sample in high half
              // low half lands at the lower byte address
              dma_wdata <= mode[`PDMC_BIT_OPERATION] ? {smp_l, pack_low} : {smp_r, smp_l};
              pack_half <= 1'b0;
              // two samples, four bytes per word
              if (done_cnt + 32'h2 >= work_cnt) begin
                ev_set[`PDMC_BIT_END] <= 1'b1;
                if (state == ST_STOP || stop_pulse) begin
                  ev_set[`PDMC_BIT_STOPPED] <= 1'b1;
                  state <= ST_IDLE;
                end else begin
                  work_ptr  <= ptr_shadow;
                  work_cnt  <= maxcnt_shadow;
                  word_addr <= ptr_shadow;
                  done_cnt  <= `PDMC_RST_ZERO;
                  ev_set[`PDMC_BIT_STARTED] <= 1'b1;
                end
              end else if (state == ST_STOP || stop_pulse) begin
                ev_set[`PDMC_BIT_END]     <= 1'b1;
                ev_set[`PDMC_BIT_STOPPED] <= 1'b1;
                state <= ST_IDLE;
              end else begin
                done_cnt  <= done_cnt + 32'h2;
                word_addr <= word_addr + 32'h4;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // pin routing and interrupt line
  always @(posedge aclk) begin
    if (!aresetn) begin
      mic_bit_clock_out <= 1'b0;
      mic_bit_clock_oe  <= 1'b0;
      clk_pin_number    <= 6'h3f;
      din_pin_number    <= 6'h3f;
      irq               <= 1'b0;
    end else begin
      // gpio owns the pin when disabled
      mic_bit_clock_out <= route_clk ? mic_clk : gpio_clk_out;
      mic_bit_clock_oe  <= route_clk ? 1'b1 : gpio_clk_oe;
      clk_pin_number    <= psel_clk[5:0];
      din_pin_number    <= psel_din[5:0];
      irq               <= |(ev & irq_enable_mask);
    end
  end

endmodule
`default_nettype wire

// ===== dv/pdmc_capture_monitor.sv
// assertion checker for the capture block register bus and dma port
`timescale 1ns/100ps
`default_nettype none
module pdmc_capture_monitor (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // dma port
  input wire logic        dma_valid,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] dma_wdata,
  input wire logic        dma_ready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_word_stalled;
    dma_valid && !dma_ready;
  endsequence

  a_write_answer: assert property (
    s_write_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response late or bus not busy");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_answer: assert property (
    s_read_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response not held");
  a_unmapped_read: assert property (
    s_read_taken and (s_axi_araddr == 12'h00c) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_clock_reg_okay: assert property (
    s_read_taken and (s_axi_araddr == 12'h504) |=> s_axi_rresp == 2'h0)
    else $error("clock register read refused");
  a_dma_hold: assert property (
    s_word_stalled |=> dma_valid && $stable(dma_addr) && $stable(dma_wdata))
    else $error("dma word changed while stalled");
  a_dma_release: assert property (
    dma_valid && dma_ready |=> !dma_valid)
    else $error("dma word repeated after take");
  a_dma_aligned: assert property (
    dma_valid |-> dma_addr[1:0] == 2'h0)
    else $error("dma address not word aligned");
endmodule

bind pdmc_capture pdmc_capture_monitor u_pdmc_capture_monitor (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .dma_valid     (dma_valid),
  .dma_addr      (dma_addr),
  .dma_wdata     (dma_wdata),
  .dma_ready     (dma_ready)
);
`default_nettype wire

// ===== dv/pdmc_mic_pair.sv
// model of a left and a right microphone sharing one data line
`timescale 1ns/100ps
`default_nettype none
module pdmc_mic_pair #(
  parameter logic LEFT_BIT  = 1'b1,
  parameter logic RIGHT_BIT = 1'b0
) (
  // clock pin from the block
  input wire logic mic_bit_clock_out,
  input wire logic mic_bit_clock_oe,
  // shared data line
  output logic     mic_data
);
  logic drv = 1'b0;
  // left drives while clock high, right while low
  always @* begin
    if (mic_bit_clock_oe) begin
      drv = mic_bit_clock_out ? LEFT_BIT : RIGHT_BIT;
    end
  end
  // undriven clock: line shows the inverse of the last driven value
  assign #5 mic_data = mic_bit_clock_oe ? drv : ~drv;
endmodule
`default_nettype wire

// ===== dv/pdmc_capture_tb.sv
// self-checking bench for the microphone capture block
`timescale 1ns/100ps
`default_nettype none
module pdmc_capture_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        dma_ready = 1'b0;
  logic        gpio_clk_out = 1'b0;
  logic        gpio_clk_oe = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, dma_valid;
  logic        clk_out, clk_oe, mic_data, irq;
  logic [1:0]  bresp, rresp, bres, rres;
  logic [31:0] rdata, dma_addr, dma_wdata, rdat;
  logic [5:0]  clk_pin, din_pin;
  logic [31:0] qa[$];
  logic [31:0] qd[$];
  int          bad_count = 0;
  int          checks = 0;

  pdmc_capture u_pdmc_capture (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dma_valid(dma_valid), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ready(dma_ready),
    .gpio_clk_out(gpio_clk_out), .gpio_clk_oe(gpio_clk_oe),
    .mic_bit_clock_out(clk_out), .mic_bit_clock_oe(clk_oe), .clk_pin_number(clk_pin),
    .mic_data_in(mic_data), .din_pin_number(din_pin), .irq(irq));

  pdmc_mic_pair u_pdmc_mic_pair (
    .mic_bit_clock_out(clk_out), .mic_bit_clock_oe(clk_oe), .mic_data(mic_data));

  always #20 aclk = ~aclk;

  // ram side takes each word after a one cycle stall
  always @(posedge aclk) begin
    dma_ready <= dma_valid && !dma_ready;
    if (dma_valid && dma_ready) begin
      qa.push_back(dma_addr);
      qd.push_back(dma_wdata);
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bres = bresp;
    bready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdat = rdata;
    rres = rresp;
    rready <= 1'b0;
    chk(what, rdat, exp);
  endtask

  task automatic waitw(input int n);
    // a frame lasts 512 cycles and a mono word needs two of them
    for (int i = 0; i < 8000 && qa.size() < n; i++) @(posedge aclk);
  endtask

  task automatic t_regs;
    rchk("enable reset", 12'h500, 32'h0);
    rchk("clock reset", 12'h504, 32'h08400000);
    rchk("mask reset", 12'h300, 32'h0);
    wr(12'h304, 32'h5);
    wr(12'h304, 32'h0);
    rchk("set readback", 12'h304, 32'h5);
    wr(12'h308, 32'h1);
    rchk("clear readback", 12'h308, 32'h4);
    wr(12'h300, 32'h3);
    rchk("mask write", 12'h300, 32'h3);
    rchk("unmapped data", 12'h00c, 32'h0);
    chk("unmapped read", {30'h0, rres}, 32'h2);
    wr(12'h00c, 32'h1);
    chk("unmapped write", {30'h0, bres}, 32'h2);
  endtask

  task automatic t_pins;
    wr(12'h540, 32'h0000000a);
    wr(12'h544, 32'h00000025);
    gpio_clk_out <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("disabled level", {31'h0, clk_out}, 32'h1);
    wr(12'h500, 32'h1);
    repeat (2) @(posedge aclk);
    chk("clock pin", {26'h0, clk_pin}, 32'h0a);
    chk("data pin", {26'h0, din_pin}, 32'h25);
    chk("routed level", {31'h0, clk_out}, 32'h0);
    wr(12'h540, 32'h8000000a);
    repeat (2) @(posedge aclk);
    chk("disconnected level", {31'h0, clk_out}, 32'h1);
    // clock pin parked low as gpio
    gpio_clk_out <= 1'b0;
    wr(12'h540, 32'h0000000a);
  endtask

  task automatic t_stereo;
    wr(12'h504, 32'h20000000);
    wr(12'h508, 32'h0);
    wr(12'h560, 32'h20000000);
    wr(12'h564, 32'h4);
    wr(12'h304, 32'h7);
    wr(12'h000, 32'h1);
    rchk("started", 12'h100, 32'h1);
    wr(12'h100, 32'h0);
    wr(12'h560, 32'h20000100);
    wr(12'h564, 32'h8);
    waitw(2);
    chk("first addr", qa[0], 32'h20000000);
    chk("second addr", qa[1], 32'h20000004);
    // first word skipped as settling data
    chk("stereo word", qd[1], 32'hc0004000);
    rchk("end event", 12'h108, 32'h1);
    rchk("restarted", 12'h100, 32'h1);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(12'h108, 32'h0);
    waitw(3);
    chk("next buffer", qa[2], 32'h20000100);
    wr(12'h004, 32'h1);
    waitw(4);
    chk("stop word", qa[3], 32'h20000104);
    chk("stop data", qd[3], 32'hc0004000);
    rchk("stopped", 12'h104, 32'h1);
    rchk("end after stop", 12'h108, 32'h1);
    wr(12'h308, 32'h7);
    rchk("mask cleared", 12'h300, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    repeat (1200) @(posedge aclk);
    chk("idle after stop", qa.size(), 32'h4);
  endtask

  task automatic t_mono;
    qa.delete();
    qd.delete();
    wr(12'h508, 32'h3);
    wr(12'h560, 32'h20000200);
    wr(12'h564, 32'h3);
    wr(12'h104, 32'h0);
    wr(12'h000, 32'h1);
    waitw(3);
    chk("mono last", qa[1], 32'h20000204);
    chk("mono wrap", qa[2], 32'h20000200);
    chk("mono word", qd[1], 32'hc000c000);
    chk("swapped edge", qd[2], 32'hc000c000);
    wr(12'h004, 32'h1);
    waitw(4);
    rchk("mono stopped", 12'h104, 32'h1);
    wr(12'h500, 32'h0);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_pins;
    t_stereo;
    t_mono;
    summarize;
  end

  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
